// [logic/pcg_pkg.sv]
package pcg_pkg;
    localparam logic [11:0] PCG_RUN_PORT_OFS = 12'h108;
    localparam logic [11:0] PCG_SLEEP_PORT_OFS = 12'h118;
    localparam logic [11:0] PCG_DEEP_PORT_OFS = 12'h128;
    localparam logic [11:0] PCG_DEEP_PERIPH_OFS = 12'h124;
    localparam logic [11:0] PCG_RUN_PERIPH_OFS = 12'h104;
    localparam logic [11:0] PCG_SLEEP_PERIPH_OFS = 12'h114;
    localparam logic [11:0] PCG_RUN_CONFIG_OFS = 12'h060;
    localparam logic [11:0] PCG_STATUS_OFS = 12'h200;
    localparam logic [31:0] PCG_PORT_MASK = 32'h0000_00ff;
    localparam logic [31:0] PCG_PERIPH_MASK = 32'h0001_0011;
    localparam int PCG_AUTO_GATE_BIT = 27;
    localparam int PCG_TIMER_BIT = 16;
    localparam int PCG_SERIAL_BIT = 4;
    localparam int PCG_UART_BIT = 0;
    localparam logic [31:0] PCG_RESET_VAL = 32'h0000_0000;
    localparam logic [1:0] PCG_RESP_OKAY = 2'h0;
    localparam logic [1:0] PCG_RESP_SLVERR = 2'h2;
    localparam logic [1:0] PCG_MODE_RUN = 2'h0;
    localparam logic [1:0] PCG_MODE_SLEEP = 2'h1;
    localparam logic [1:0] PCG_MODE_DEEP = 2'h2;
endpackage

// [logic/pcg_top.sv]
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module pcg_top (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [1:0] power_mode,
    input wire logic [10:0] unit_access,
    output logic [10:0] unit_fault,
    output logic [10:0] unit_clock_on
);
    // unit order: bits 7:0 ports a..h, 8 uart, 9 serial, 10 timer
    logic [31:0] run_port_clock_enable_r;
    logic [31:0] sleep_port_clock_enable_r;
    logic [31:0] deepsleep_port_clock_enable_r;
    logic [31:0] run_periph_clock_enable_r;
    logic [31:0] sleep_periph_clock_enable_r;
    logic [31:0] deepsleep_periph_clock_enable_r;
    logic [31:0] run_clock_config_r;
    logic [1:0] mode_s1_r;
    logic [1:0] mode_s2_r;
    logic [10:0] acc_s1_r;
    logic [10:0] acc_s2_r;
    logic [11:0] aw_addr_r;
    logic aw_held_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    logic w_held_r;

    // mode and access strobes come from other logic; synchronise them
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            mode_s1_r <= 2'h0;
            mode_s2_r <= 2'h0;
            acc_s1_r <= 11'h000;
            acc_s2_r <= 11'h000;
        end else begin
            mode_s1_r <= power_mode;
            mode_s2_r <= mode_s1_r;
            acc_s1_r <= unit_access;
            acc_s2_r <= acc_s1_r;
        end
    end

    // select the active gating set
    wire logic auto_gate = run_clock_config_r[pcg_pkg::PCG_AUTO_GATE_BIT];
    wire logic use_sleep = auto_gate &&
        (mode_s2_r == pcg_pkg::PCG_MODE_SLEEP);
    wire logic use_deep = auto_gate &&
        (mode_s2_r == pcg_pkg::PCG_MODE_DEEP);
    // with auto gating clear the run set stays in force in all modes
    wire logic [31:0] port_set = use_deep ? deepsleep_port_clock_enable_r :
        use_sleep ? sleep_port_clock_enable_r :
        run_port_clock_enable_r;
    wire logic [31:0] periph_set = use_deep ?
        deepsleep_periph_clock_enable_r : use_sleep ?
        sleep_periph_clock_enable_r : run_periph_clock_enable_r;
    wire logic [10:0] gate_nxt = {periph_set[pcg_pkg::PCG_TIMER_BIT],
        periph_set[pcg_pkg::PCG_SERIAL_BIT],
        periph_set[pcg_pkg::PCG_UART_BIT], port_set[7:0]};

    // per-unit clock enable and fault, registered
    genvar gi;
    generate
        for (gi = 0; gi < 11; gi++) begin : g_unit
            always_ff @(posedge clk_sys) begin
                if (rst) begin
                    unit_clock_on[gi] <= 1'b0;
                    unit_fault[gi] <= 1'b0;
                end else begin
                    unit_clock_on[gi] <= gate_nxt[gi];
                    // access to a stopped unit is faulted, not passed on
                    unit_fault[gi] <= acc_s2_r[gi] & ~gate_nxt[gi];
                end
            end
        end
    endgenerate

    // write channel: address and data may arrive in either order
    wire logic aw_take = s_axi_awvalid && s_axi_awready;
    wire logic w_take = s_axi_wvalid && s_axi_wready;
    wire logic [11:0] wr_addr = aw_held_r ? aw_addr_r : s_axi_awaddr;
    wire logic [31:0] wr_data = w_held_r ? w_data_r : s_axi_wdata;
    wire logic [3:0] wr_strb = w_held_r ? w_strb_r : s_axi_wstrb;
    wire logic aw_have = aw_held_r || aw_take;
    wire logic w_have = w_held_r || w_take;
    wire logic wr_go = aw_have && w_have && !s_axi_bvalid;
    wire logic [31:0] wmask = {{8{wr_strb[3]}}, {8{wr_strb[2]}},
        {8{wr_strb[1]}}, {8{wr_strb[0]}}};
    wire logic [9:0] wr_word = wr_addr[11:2];
    wire logic wr_run_port = wr_word == pcg_pkg::PCG_RUN_PORT_OFS[11:2];
    wire logic wr_slp_port = wr_word == pcg_pkg::PCG_SLEEP_PORT_OFS[11:2];
    wire logic wr_dp_port = wr_word == pcg_pkg::PCG_DEEP_PORT_OFS[11:2];
    wire logic wr_run_per = wr_word == pcg_pkg::PCG_RUN_PERIPH_OFS[11:2];
    wire logic wr_slp_per = wr_word == pcg_pkg::PCG_SLEEP_PERIPH_OFS[11:2];
    wire logic wr_dp_per = wr_word == pcg_pkg::PCG_DEEP_PERIPH_OFS[11:2];
    wire logic wr_cfg = wr_word == pcg_pkg::PCG_RUN_CONFIG_OFS[11:2];
    wire logic wr_stat = wr_word == pcg_pkg::PCG_STATUS_OFS[11:2];
    wire logic wr_hit = wr_run_port || wr_slp_port || wr_dp_port ||
        wr_run_per || wr_slp_per || wr_dp_per || wr_cfg || wr_stat;
    wire logic [31:0] cfg_mask =
        32'h0000_0001 << pcg_pkg::PCG_AUTO_GATE_BIT;

    function automatic logic [31:0] merge(input logic [31:0] old,
        input logic [31:0] keep);
        merge = ((old & ~wmask) | (wr_data & wmask)) & keep;
    endfunction

    // channel handshakes; each ready drops once its beat is held
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            aw_addr_r <= 12'h000;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= pcg_pkg::PCG_RESP_OKAY;
        end else begin
            s_axi_awready <= !aw_have || wr_go ? !wr_go : 1'b0;
            s_axi_wready <= !w_have || wr_go ? !wr_go : 1'b0;
            if (aw_take) begin
                aw_addr_r <= s_axi_awaddr;
            end
            if (w_take) begin
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            aw_held_r <= aw_have && !wr_go;
            w_held_r <= w_have && !wr_go;
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? pcg_pkg::PCG_RESP_OKAY :
                    pcg_pkg::PCG_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                // ready reopens here too, but it is already set again the cycle after the write, while the response still waits
                s_axi_awready <= !aw_have;
                s_axi_wready <= !w_have;
            end
        end
    end

    // register file; only documented enable bits are writable
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            run_port_clock_enable_r <= pcg_pkg::PCG_RESET_VAL;
            sleep_port_clock_enable_r <= pcg_pkg::PCG_RESET_VAL;
            deepsleep_port_clock_enable_r <= pcg_pkg::PCG_RESET_VAL;
            run_periph_clock_enable_r <= pcg_pkg::PCG_RESET_VAL;
            sleep_periph_clock_enable_r <= pcg_pkg::PCG_RESET_VAL;
            deepsleep_periph_clock_enable_r <= pcg_pkg::PCG_RESET_VAL;
            run_clock_config_r <= pcg_pkg::PCG_RESET_VAL;
        end else if (wr_go) begin
            if (wr_run_port) begin
                run_port_clock_enable_r <= merge(run_port_clock_enable_r,
                    pcg_pkg::PCG_PORT_MASK);
            end else if (wr_slp_port) begin
                sleep_port_clock_enable_r <= merge(
                    sleep_port_clock_enable_r, pcg_pkg::PCG_PORT_MASK);
            end else if (wr_dp_port) begin
                deepsleep_port_clock_enable_r <= merge(
                    deepsleep_port_clock_enable_r, pcg_pkg::PCG_PORT_MASK);
            end else if (wr_run_per) begin
                run_periph_clock_enable_r <= merge(
                    run_periph_clock_enable_r, pcg_pkg::PCG_PERIPH_MASK);
            end else if (wr_slp_per) begin
                sleep_periph_clock_enable_r <= merge(
                    sleep_periph_clock_enable_r, pcg_pkg::PCG_PERIPH_MASK);
            end else if (wr_dp_per) begin
                deepsleep_periph_clock_enable_r <= merge(
                    deepsleep_periph_clock_enable_r,
                    pcg_pkg::PCG_PERIPH_MASK);
            end else if (wr_cfg) begin
                run_clock_config_r <= merge(run_clock_config_r, cfg_mask);
            end
        end
    end

    // read decode; reserved bits are never stored so they read zero
    wire logic [9:0] rd_word = s_axi_araddr[11:2];
    wire logic [31:0] status_word = {19'h0_0000, mode_s2_r,
        unit_clock_on}; // live gating state
    wire logic rd_run_port = rd_word == pcg_pkg::PCG_RUN_PORT_OFS[11:2];
    wire logic rd_slp_port = rd_word == pcg_pkg::PCG_SLEEP_PORT_OFS[11:2];
    wire logic rd_dp_port = rd_word == pcg_pkg::PCG_DEEP_PORT_OFS[11:2];
    wire logic rd_run_per = rd_word == pcg_pkg::PCG_RUN_PERIPH_OFS[11:2];
    wire logic rd_slp_per = rd_word == pcg_pkg::PCG_SLEEP_PERIPH_OFS[11:2];
    wire logic rd_dp_per = rd_word == pcg_pkg::PCG_DEEP_PERIPH_OFS[11:2];
    wire logic rd_cfg = rd_word == pcg_pkg::PCG_RUN_CONFIG_OFS[11:2];
    wire logic rd_stat = rd_word == pcg_pkg::PCG_STATUS_OFS[11:2];
    wire logic rd_hit = rd_run_port || rd_slp_port || rd_dp_port ||
        rd_run_per || rd_slp_per || rd_dp_per || rd_cfg || rd_stat;
    wire logic [31:0] rd_val =
        rd_run_port ? run_port_clock_enable_r :
        rd_slp_port ? sleep_port_clock_enable_r :
        rd_dp_port ? deepsleep_port_clock_enable_r :
        rd_run_per ? run_periph_clock_enable_r :
        rd_slp_per ? sleep_periph_clock_enable_r :
        rd_dp_per ? deepsleep_periph_clock_enable_r :
        rd_cfg ? run_clock_config_r :
        rd_stat ? status_word : 32'h0000_0000;
    wire logic ar_take = s_axi_arvalid && s_axi_arready;

    // read channel: one read at a time, arready closed while rvalid
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= pcg_pkg::PCG_RESP_OKAY;
        end else if (ar_take) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_val;
            s_axi_rresp <= rd_hit ? pcg_pkg::PCG_RESP_OKAY :
                pcg_pkg::PCG_RESP_SLVERR;
        end else if (s_axi_rvalid) begin
            s_axi_rvalid <= !s_axi_rready;
            s_axi_arready <= s_axi_rready;
        end else begin
            s_axi_arready <= 1'b1;
        end
    end
endmodule // pcg_top

// [verification/pcg_assertions.sv]
`timescale 1ns/1ps
module pcg_assertions (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [1:0] power_mode,
    input wire logic [10:0] unit_access,
    input wire logic [10:0] unit_fault,
    input wire logic [10:0] unit_clock_on
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // both write beats taken at one edge
    sequence s_wr_both;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    // run mode settled first, since the mode input passes sync flops
    sequence s_run_port_wr;
        (power_mode == pcg_pkg::PCG_MODE_RUN)[*4] ##0 s_wr_both ##0
        (s_axi_awaddr == pcg_pkg::PCG_RUN_PORT_OFS && s_axi_wstrb == 4'hf);
    endsequence
    property p_reset_clear;
        $fell(rst) |-> !unit_clock_on && !s_axi_bvalid && !s_axi_rvalid;
    endproperty
    property p_run_gate;
        s_run_port_wr |-> ##2 unit_clock_on[7:0] == $past(s_axi_wdata[7:0], 2);
    endproperty
    property p_clock_steady;
        (!s_axi_bvalid && $stable(power_mode))[*5] |=> $stable(unit_clock_on);
    endproperty
    property p_fault;
        ($stable(unit_access) && $stable(unit_clock_on))[*5]
        |-> unit_fault == (unit_access & ~unit_clock_on);
    endproperty
    property p_port_rsvd;
        s_axi_arvalid && s_axi_arready && s_axi_araddr[3:0] == 4'h8 &&
        s_axi_araddr[11:8] == 4'h1 |=> !s_axi_rdata[31:8];
    endproperty
    property p_wr_resp;
        s_wr_both |=> s_axi_bvalid ##0 !s_axi_awready;
    endproperty
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
    endproperty
    property p_rd_resp;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
    endproperty
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("not clear");
    a_run_gate: assert property (p_run_gate) else $error("gate late");
    a_clock_steady: assert property (p_clock_steady) else $error("drift");
    a_fault: assert property (p_fault) else $error("fault wrong");
    a_port_rsvd: assert property (p_port_rsvd) else $error("rsvd set");
    a_wr_resp: assert property (p_wr_resp) else $error("no bvalid");
    a_b_hold: assert property (p_b_hold) else $error("b dropped");
    a_rd_resp: assert property (p_rd_resp) else $error("no rvalid");
    a_r_hold: assert property (p_r_hold) else $error("r dropped");
endmodule // pcg_assertions
bind pcg_top pcg_assertions i_pcg_assertions (.clk_sys, .rst, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
    .s_axi_rready, .power_mode, .unit_access, .unit_fault, .unit_clock_on);

// [verification/pcg_top_tb.sv]
`timescale 1ns/1ps
module pcg_top_tb;
    logic clk_sys = '0;
    logic rst = '1;
    logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = '0;
    logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
    logic s_axi_arvalid = '0, s_axi_rready = '0, s_axi_awready;
    logic s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, power_mode = '0;
    logic [10:0] unit_access, unit_fault, unit_clock_on, want = '0;
    int n_fail = 0, compares = 0;
    initial forever #2.5 clk_sys = ~clk_sys;
    pcg_top i_pcg_top (.clk_sys, .rst, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .power_mode,
        .unit_access, .unit_fault, .unit_clock_on);
    pcg_unit_model i_pcg_unit_model (.clk_sys, .rst, .want, .unit_access);
    task automatic cmp(string nm, logic [31:0] e, logic [31:0] g);
        compares++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch %s exp %h got %h", nm, e, g);
        end
    endtask
    // response ready is held back one cycle to stall the slave
    task automatic wr(logic [11:0] a, logic [31:0] d, logic [1:0] er);
        int n = 0;
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hf;
        s_axi_awvalid <= '1;
        s_axi_wvalid <= '1;
        do begin
            @(posedge clk_sys);
            if (s_axi_awready) s_axi_awvalid <= '0;
            if (s_axi_wready) s_axi_wvalid <= '0;
            if (n == 1) s_axi_bready <= '1;
            n++;
        end while (!(s_axi_bvalid && s_axi_bready) && n < 50);
        // a write that never answers counts against the run
        if (n >= 50) n_fail++;
        s_axi_bready <= '0;
        cmp("bresp", er, s_axi_bresp);
    endtask
    task automatic rd(logic [11:0] a, logic [31:0] e, logic [1:0] er);
        int n = 0;
        @(posedge clk_sys);
        s_axi_araddr <= a;
        s_axi_arvalid <= '1;
        do begin
            @(posedge clk_sys);
            if (s_axi_arready) s_axi_arvalid <= '0;
            if (n == 1) s_axi_rready <= '1;
            n++;
        end while (!(s_axi_rvalid && s_axi_rready) && n < 50);
        if (n >= 50) n_fail++;
        s_axi_rready <= '0;
        cmp("rdata", e, s_axi_rdata);
        cmp("rresp", er, s_axi_rresp);
    endtask
    // mode and enables settle within a few edges of sync flops
    task automatic chk_on(logic [1:0] m, logic [10:0] e);
        power_mode <= m;
        repeat (6) @(posedge clk_sys);
        cmp("clock_on", e, unit_clock_on);
    endtask
    task automatic give_verdict;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge clk_sys);
        rst <= '0;
        rd(pcg_pkg::PCG_RUN_PORT_OFS, '0, pcg_pkg::PCG_RESP_OKAY);
        rd(pcg_pkg::PCG_SLEEP_PORT_OFS, '0, pcg_pkg::PCG_RESP_OKAY);
        rd(pcg_pkg::PCG_DEEP_PORT_OFS, '0, pcg_pkg::PCG_RESP_OKAY);
        rd(pcg_pkg::PCG_DEEP_PERIPH_OFS, '0, pcg_pkg::PCG_RESP_OKAY);
        // walking one over the eight port enables
        for (int i = 0; i < 8; i++) begin
            wr(pcg_pkg::PCG_RUN_PORT_OFS, 32'h1 << i, 2'h0);
            chk_on(2'h0, 11'h1 << i);
        end
        wr(pcg_pkg::PCG_RUN_PORT_OFS, 32'hffff_ffff, 2'h0);
        rd(pcg_pkg::PCG_RUN_PORT_OFS, 32'h0000_00ff, 2'h0);
        wr(pcg_pkg::PCG_DEEP_PERIPH_OFS, 32'hffff_ffff, 2'h0);
        rd(pcg_pkg::PCG_DEEP_PERIPH_OFS, 32'h0001_0011, 2'h0);
        wr(pcg_pkg::PCG_SLEEP_PORT_OFS, 32'h0000_000f, 2'h0);
        wr(pcg_pkg::PCG_DEEP_PORT_OFS, 32'h0000_00f0, 2'h0);
        chk_on(2'h1, 11'h0ff);
        chk_on(2'h2, 11'h0ff);
        chk_on(2'h0, 11'h0ff);
        wr(pcg_pkg::PCG_RUN_CONFIG_OFS, 32'h0800_0000, 2'h0);
        chk_on(2'h1, 11'h00f);
        chk_on(2'h2, 11'h7f0);
        chk_on(2'h0, 11'h0ff);
        // mode code 3 is treated as run; status shows mode and gates
        chk_on(2'h3, 11'h0ff);
        rd(pcg_pkg::PCG_STATUS_OFS, {19'h0_0000, 2'h3, 11'h0ff}, 2'h0);
        chk_on(2'h0, 11'h0ff);
        // only port a enabled, then ports a and b used
        wr(pcg_pkg::PCG_RUN_PORT_OFS, 32'h0000_0001, 2'h0);
        want <= 11'h003;
        repeat (7) @(posedge clk_sys);
        cmp("fault", 11'h002, unit_fault);
        want <= '0;
        rd(12'h300, '0, pcg_pkg::PCG_RESP_SLVERR);
        wr(12'h300, 32'h0000_00ff, pcg_pkg::PCG_RESP_SLVERR);
        // a second reset in mid-run must clear the clock gates and the run port enables again
        rst <= '1;
        repeat (2) @(posedge clk_sys);
        rst <= '0;
        cmp("clock_on", '0, unit_clock_on);
        rd(pcg_pkg::PCG_RUN_PORT_OFS, '0, pcg_pkg::PCG_RESP_OKAY);
        give_verdict;
    end
    // a hang is cut short well past the few hundred cycles needed
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_fail++;
        give_verdict;
    end
endmodule // pcg_top_tb

// [verification/pcg_unit_model.sv]
`timescale 1ns/1ps
// far-side units: a master targets a unit while want is high
module pcg_unit_model (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [10:0] want,
    output logic [10:0] unit_access
);
    // registered so access only moves just after an edge
    always_ff @(posedge clk_sys) begin
        unit_access <= rst ? '0 : want;
    end
endmodule // pcg_unit_model
